// file: rtl/gpl_cfg.svh
// gpl_cfg.svh - offsets, field positions, reset values and timing counts
// assumes: included by bare name from the filter, pwm channel and top design files of the io pin unit
`ifndef GPL_CFG_SVH
`define GPL_CFG_SVH

// ----------------------------------------------------------------------
// register offsets in the upstream port space
// ----------------------------------------------------------------------
`define GPL_OFF_CONFIG    12'h62C
`define GPL_OFF_FLAGS     12'h630
`define GPL_OFF_DUTY      12'h634
`define GPL_OFF_RAMP      12'h638
`define GPL_OFF_DIVIDER   12'h63C

// ----------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------
`define GPL_NUM_PINS      4
`define GPL_CFG_W         24
`define GPL_INLVL_LSB     24
`define GPL_BYTE_W        8
`define GPL_DUTY_MAX      8'hFF
`define GPL_DUTY_MIN      8'h00
`define GPL_STEP_LAST     8'hFF
`define GPL_RAMP_OFF      8'h00

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define GPL_RST_CONFIG    24'h000000
`define GPL_RST_DUTY      32'h00000000
`define GPL_RST_RAMP      32'h00000000
`define GPL_RST_DIVIDER   8'h00
`define GPL_RST_FLAGS     4'h0

// ----------------------------------------------------------------------
// timing: 250 MHz core clock, 62.5 MHz step reference
// ----------------------------------------------------------------------
`define GPL_CLK_HZ        250000000
`define GPL_REF_HZ        62500000
`define GPL_PRESCALE_LAST 2'(`GPL_CLK_HZ / `GPL_REF_HZ - 1)
`define GPL_DIV_ZERO      9'h100
`define GPL_DB_TIME_NS    1000
`define GPL_DB_CYCLES     16'(`GPL_DB_TIME_NS * (`GPL_CLK_HZ / 1000000) / 1000)

`endif

// file: rtl/gpl_pkg.sv
// gpl_pkg.sv - types shared by the io pin unit
// assumes: gpl_cfg.svh holds the numbers these types carry
package gpl_pkg;

    // per-pin control fields held in the pin config register
    typedef struct packed {
        logic [3:0] ramp_down;
        logic [3:0] irq_en;
        logic [3:0] db_en;
        logic [3:0] pwm_en;
        logic [3:0] out_lvl;
        logic [3:0] dir_out;
    } gpl_pin_cfg_s;

    // one access on the internal configuration port
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } gpl_cfg_req_s;

endpackage

// file: rtl/gpl_in_filter.sv
// gpl_in_filter.sv - pin synchroniser with optional de-bounce and change pulse
// assumes: pin_i is asynchronous to clk_i; one instance per pin
`include "gpl_cfg.svh"

module gpl_in_filter #(
    parameter logic [15:0] DB_CYCLES = `GPL_DB_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic pin_i,
    input  wire logic db_en_i,
    output logic      level_o,
    output logic      change_o
);
    import gpl_pkg::*;

    logic [2:0]  sync_reg;
    logic [2:0]  sync_next;
    logic        acc_reg;
    logic        acc_next;
    logic        level_reg;
    logic        level_next;
    logic        chg_reg;
    logic        chg_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;

    // three-stage sync, level accepted once stages two and three agree
    always_comb begin
        sync_next  = {sync_reg[1:0], pin_i};
        acc_next   = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : acc_reg;
        level_next = level_reg;
        chg_next   = 1'b0;
        cnt_next   = 16'h0000;
        if (acc_reg != level_reg) begin
            // stable-time filter, bypassed when de-bounce is off
            if (!db_en_i || cnt_reg >= DB_CYCLES - 16'h0001) begin
                level_next = acc_reg;
                chg_next   = 1'b1;
            end else begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sync_reg  <= 3'h0;
            acc_reg   <= 1'b0;
            level_reg <= 1'b0;
            chg_reg   <= 1'b0;
            cnt_reg   <= 16'h0000;
        end else begin
            sync_reg  <= sync_next;
            acc_reg   <= acc_next;
            level_reg <= level_next;
            chg_reg   <= chg_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign level_o  = level_reg;
    assign change_o = chg_reg;

    // a change pulse always marks a new level
    chg_level_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        change_o |-> level_o != $past(level_o))
        else $error("change pulse without level change");
endmodule

// file: rtl/gpl_pwm_chan.sv
// gpl_pwm_chan.sv - one pwm compare and its ramp cycle counter
// assumes: step_i and cycle_end_i come from the shared step generator
`include "gpl_cfg.svh"

module gpl_pwm_chan (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [7:0] step_i,
    input  wire logic       cycle_end_i,
    input  wire logic [7:0] duty_i,
    input  wire logic [7:0] ramp_n_i,
    input  wire logic       clear_i,
    output logic            pwm_o,
    output logic            bump_o
);
    import gpl_pkg::*;

    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic       bump_reg;
    logic       bump_next;
    logic       pwm_reg;
    logic       pwm_next;

    // high for duty steps, low for the rest of the cycle
    always_comb begin
        pwm_next  = step_i < duty_i;
        bump_next = 1'b0;
        cnt_next  = cnt_reg;
        if (clear_i || ramp_n_i == `GPL_RAMP_OFF) begin
            cnt_next = 8'h00;
        end else if (cycle_end_i) begin
            if (cnt_reg + 8'h01 >= ramp_n_i) begin
                cnt_next  = 8'h00;
                bump_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_reg  <= 8'h00;
            bump_reg <= 1'b0;
            pwm_reg  <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            bump_reg <= bump_next;
            pwm_reg  <= pwm_next;
        end
    end

    assign pwm_o  = pwm_reg;
    assign bump_o = bump_reg;

    // a ramp step only follows a completed pwm cycle
    ramp_cause_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        bump_o |-> $past(cycle_end_i) && $past(ramp_n_i) != 8'h00)
        else $error("ramp step without cycle end");
endmodule

// file: rtl/gpl_io_top.sv
// gpl_io_top.sv - four-pin io unit: lane status, input events, static and pwm out
// assumes: one 250 MHz clock, config writes from eeprom, smbus or software
//          arrive on one internal port, lane status comes from link logic
`include "gpl_cfg.svh"

module gpl_io_top #(
    parameter logic [15:0] DB_CYCLES = `GPL_DB_CYCLES
) (
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    input  wire gpl_pkg::gpl_cfg_req_s cfg_req_i,
    output logic [31:0]               cfg_rdata_o,
    output logic                      cfg_rvalid_o,
    input  wire logic                 pin_function_select_i,
    input  wire logic [3:0]           lane_good_n_i,
    input  wire logic [3:0]           general_io_pin_i,
    output logic [3:0]                general_io_pin_o,
    output logic [3:0]                general_io_pin_oe_o,
    output logic                      event_pending_o
);
    import gpl_pkg::*;

    // ------------------------------------------------------------------
    // state and wires
    // ------------------------------------------------------------------
    gpl_pin_cfg_s cfg_reg;
    gpl_pin_cfg_s cfg_next;
    logic [3:0]   flags_reg;
    logic [3:0]   flags_next;
    logic [31:0]  duty_reg;
    logic [31:0]  duty_next;
    logic [31:0]  ramp_reg;
    logic [31:0]  ramp_next;
    logic [7:0]   div_reg;
    logic [7:0]   div_next;
    logic [31:0]  rdata_reg;
    logic [31:0]  rdata_next;
    logic         rvalid_reg;
    logic         rvalid_next;
    logic [1:0]   pre_reg;
    logic [1:0]   pre_next;
    logic [8:0]   divcnt_reg;
    logic [8:0]   divcnt_next;
    logic [7:0]   step_reg;
    logic [7:0]   step_next;
    logic [3:0]   pin_reg;
    logic [3:0]   pin_next;
    logic [3:0]   oe_reg;
    logic [3:0]   oe_next;
    logic         pend_reg;
    logic         pend_next;

    logic         wr_cfg;
    logic         wr_flags;
    logic         wr_duty;
    logic         wr_ramp;
    logic         wr_div;
    logic         ref_tick;
    logic         step_tick;
    logic         cycle_end;
    logic [8:0]   divisor;
    logic [3:0]   in_lvl;
    logic [3:0]   in_chg;
    logic [3:0]   pwm_out;
    logic [3:0]   bump;

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    // every config source shares this single write port
    assign wr_cfg   = cfg_req_i.wr && cfg_req_i.addr == `GPL_OFF_CONFIG;
    assign wr_flags = cfg_req_i.wr && cfg_req_i.addr == `GPL_OFF_FLAGS;
    assign wr_duty  = cfg_req_i.wr && cfg_req_i.addr == `GPL_OFF_DUTY;
    assign wr_ramp  = cfg_req_i.wr && cfg_req_i.addr == `GPL_OFF_RAMP;
    assign wr_div   = cfg_req_i.wr && cfg_req_i.addr == `GPL_OFF_DIVIDER;

    // ------------------------------------------------------------------
    // per-pin input filters and pwm channels
    // ------------------------------------------------------------------
    for (genvar i = 0; i < `GPL_NUM_PINS; i++) begin : g_pin
        gpl_in_filter #(
            .DB_CYCLES (DB_CYCLES)
        ) u_filter (
            .clk_i     (clk_i),
            .sys_rst_i (sys_rst_i),
            .pin_i     (general_io_pin_i[i]),
            .db_en_i   (cfg_reg.db_en[i]),
            .level_o   (in_lvl[i]),
            .change_o  (in_chg[i])
        );
        gpl_pwm_chan u_pwm (
            .clk_i       (clk_i),
            .sys_rst_i   (sys_rst_i),
            .step_i      (step_reg),
            .cycle_end_i (cycle_end),
            .duty_i      (duty_reg[i*`GPL_BYTE_W +: `GPL_BYTE_W]),
            .ramp_n_i    (ramp_reg[i*`GPL_BYTE_W +: `GPL_BYTE_W]),
            .clear_i     (wr_ramp),
            .pwm_o       (pwm_out[i]),
            .bump_o      (bump[i])
        );
    end

    // ------------------------------------------------------------------
    // shared step generator
    // ------------------------------------------------------------------
    // 00h selects the largest divisor
    assign divisor   = (div_reg == `GPL_RST_DIVIDER) ? `GPL_DIV_ZERO
                                                     : {1'b0, div_reg};
    assign ref_tick  = pre_reg == `GPL_PRESCALE_LAST;
    assign step_tick = ref_tick && divcnt_reg == divisor - 9'h001;
    assign cycle_end = step_tick && step_reg == `GPL_STEP_LAST;

    // prescale to 62.5 MHz, divide, count 256 steps for all pins
    always_comb begin
        pre_next    = ref_tick ? 2'h0 : pre_reg + 2'h1;
        divcnt_next = divcnt_reg;
        step_next   = step_reg;
        if (wr_div) begin
            divcnt_next = 9'h000; // restart so a smaller divisor is not overrun
        end else if (ref_tick) begin
            divcnt_next = step_tick ? 9'h000 : divcnt_reg + 9'h001;
        end
        if (step_tick) begin
            step_next = step_reg + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pre_reg    <= 2'h0;
            divcnt_reg <= 9'h000;
            step_reg   <= 8'h00;
        end else begin
            pre_reg    <= pre_next;
            divcnt_reg <= divcnt_next;
            step_reg   <= step_next;
        end
    end

    // ------------------------------------------------------------------
    // software registers and hardware updates
    // ------------------------------------------------------------------
    always_comb begin
        cfg_next   = wr_cfg ? gpl_pin_cfg_s'(cfg_req_i.wdata[`GPL_CFG_W-1:0]) : cfg_reg;
        ramp_next  = wr_ramp ? cfg_req_i.wdata : ramp_reg;
        div_next   = wr_div ? cfg_req_i.wdata[`GPL_BYTE_W-1:0] : div_reg;
        duty_next  = duty_reg;
        flags_next = flags_reg;
        for (int i = 0; i < `GPL_NUM_PINS; i++) begin
            if (wr_duty) begin
                duty_next[i*`GPL_BYTE_W +: `GPL_BYTE_W] =
                    cfg_req_i.wdata[i*`GPL_BYTE_W +: `GPL_BYTE_W];
            end else if (bump[i] && cfg_reg.pwm_en[i]) begin
                // step toward the chosen end and stop there
                if (cfg_reg.ramp_down[i]) begin
                    if (duty_reg[i*`GPL_BYTE_W +: `GPL_BYTE_W] != `GPL_DUTY_MIN) begin
                        duty_next[i*`GPL_BYTE_W +: `GPL_BYTE_W] =
                            duty_reg[i*`GPL_BYTE_W +: `GPL_BYTE_W] - 8'h01;
                    end
                end else if (duty_reg[i*`GPL_BYTE_W +: `GPL_BYTE_W] != `GPL_DUTY_MAX) begin
                    duty_next[i*`GPL_BYTE_W +: `GPL_BYTE_W] =
                        duty_reg[i*`GPL_BYTE_W +: `GPL_BYTE_W] + 8'h01;
                end
            end
            // sticky event flag, a new event beats the write-one clear
            if (wr_flags && cfg_req_i.wdata[i]) begin
                flags_next[i] = 1'b0;
            end
            if (in_chg[i] && cfg_reg.irq_en[i] && !cfg_reg.dir_out[i]) begin
                flags_next[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cfg_reg   <= gpl_pin_cfg_s'(`GPL_RST_CONFIG);
            flags_reg <= `GPL_RST_FLAGS;
            duty_reg  <= `GPL_RST_DUTY;
            ramp_reg  <= `GPL_RST_RAMP;
            div_reg   <= `GPL_RST_DIVIDER;
        end else begin
            cfg_reg   <= cfg_next;
            flags_reg <= flags_next;
            duty_reg  <= duty_next;
            ramp_reg  <= ramp_next;
            div_reg   <= div_next;
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    // unmapped offsets read as zero
    always_comb begin
        rvalid_next = cfg_req_i.rd;
        rdata_next  = rdata_reg;
        if (cfg_req_i.rd) begin
            case (cfg_req_i.addr)
                `GPL_OFF_CONFIG:  rdata_next = {4'h0, in_lvl, cfg_reg};
                `GPL_OFF_FLAGS:   rdata_next = {28'h0000000, flags_reg};
                `GPL_OFF_DUTY:    rdata_next = duty_reg;
                `GPL_OFF_RAMP:    rdata_next = ramp_reg;
                `GPL_OFF_DIVIDER: rdata_next = {24'h000000, div_reg};
                default:          rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_reg  <= 32'h00000000;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ------------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------------
    // lane status by default, then static level or pwm per pin
    always_comb begin
        pin_next  = 4'h0;
        oe_next   = 4'h0;
        pend_next = |(flags_reg & cfg_reg.irq_en);
        for (int i = 0; i < `GPL_NUM_PINS; i++) begin
            if (pin_function_select_i) begin
                pin_next[i] = lane_good_n_i[i];
                oe_next[i]  = 1'b1;
            end else if (cfg_reg.dir_out[i]) begin
                pin_next[i] = cfg_reg.pwm_en[i] ? pwm_out[i] : cfg_reg.out_lvl[i];
                oe_next[i]  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_reg  <= 4'h0;
            oe_reg   <= 4'h0;
            pend_reg <= 1'b0;
        end else begin
            pin_reg  <= pin_next;
            oe_reg   <= oe_next;
            pend_reg <= pend_next;
        end
    end

    assign cfg_rdata_o         = rdata_reg;
    assign cfg_rvalid_o        = rvalid_reg;
    assign general_io_pin_o    = pin_reg;
    assign general_io_pin_oe_o = oe_reg;
    assign event_pending_o     = pend_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    lane_route_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pin_function_select_i |=> general_io_pin_oe_o == 4'hF
                                  && general_io_pin_o == $past(lane_good_n_i))
        else $error("lane status not routed to pins");

    static_out_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !pin_function_select_i && cfg_reg.dir_out[0] && !cfg_reg.pwm_en[0]
        |=> general_io_pin_oe_o[0] && general_io_pin_o[0] == $past(cfg_reg.out_lvl[0]))
        else $error("static output level wrong");

    pin_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cfg_req_i.rd && cfg_req_i.addr == `GPL_OFF_CONFIG
        |=> cfg_rvalid_o && cfg_rdata_o[27:24] == $past(in_lvl))
        else $error("pin level read wrong");

    edge_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        in_chg[0] && cfg_reg.irq_en[0] && !cfg_reg.dir_out[0] |=> flags_reg[0])
        else $error("pin change not flagged");

    flag_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        flags_reg[0] && !(wr_flags && cfg_req_i.wdata[0]) |=> flags_reg[0])
        else $error("event flag lost without clear");

    step_fast_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        step_tick && div_reg == 8'h01 && !wr_div ##1 !wr_div [*3] |=> step_tick)
        else $error("fastest step not four clocks");

    step_wrap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        step_tick && step_reg == 8'hFF |=> step_reg == 8'h00)
        else $error("step count not 256");

    ramp_stop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        duty_reg[7:0] == 8'hFF && !cfg_reg.ramp_down[0] && !wr_duty
        |=> duty_reg[7:0] == 8'hFF)
        else $error("ramp passed the top");
endmodule

// file: testbench/gpl_pin_model.sv
// gpl_pin_model.sv - external side of the four io pins: leds or driven signals
// assumes: the bench sets the level that an outside source puts on each pin
module gpl_pin_model (
    input  wire logic [3:0] pin_drive_i,
    input  wire logic [3:0] pin_oe_i,
    input  wire logic [3:0] ext_lvl_i,
    output logic      [3:0] pin_lvl_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // wire level: the unit wins where it drives, else the outside source
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_lvl_o[i] = pin_oe_i[i] ? pin_drive_i[i] : ext_lvl_i[i];
        end
    end
endmodule

// file: testbench/tb_top.sv
// tb_top.sv - self-checking bench for the four-pin io unit
// assumes: gpl_io_top with DB_CYCLES = 4, pin model on the pin side
`include "gpl_cfg.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import gpl_pkg::*;

    logic         clk_i = 1'b0;
    logic         sys_rst_i = 1'b1;
    gpl_cfg_req_s cfg_req_i = '0;
    logic  [31:0] cfg_rdata_o;
    logic         cfg_rvalid_o;
    logic         pin_function_select_i = 1'b1;
    logic  [3:0]  lane_good_n_i = 4'h3;
    logic  [3:0]  general_io_pin_i;
    logic  [3:0]  general_io_pin_o;
    logic  [3:0]  general_io_pin_oe_o;
    logic         event_pending_o;
    logic  [3:0]  ext_lvl = 4'h0;
    int           n_mismatch = 0;
    int           samples_checked = 0;
    int           cyc = 0;

    gpl_io_top #(.DB_CYCLES(16'h0004)) gpl_io_top_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_req_i(cfg_req_i),
        .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
        .pin_function_select_i(pin_function_select_i), .lane_good_n_i(lane_good_n_i),
        .general_io_pin_i(general_io_pin_i), .general_io_pin_o(general_io_pin_o),
        .general_io_pin_oe_o(general_io_pin_oe_o), .event_pending_o(event_pending_o));

    gpl_pin_model gpl_pin_model_i (
        .pin_drive_i(general_io_pin_o), .pin_oe_i(general_io_pin_oe_o),
        .ext_lvl_i(ext_lvl), .pin_lvl_o(general_io_pin_i));

    // ------------------------------------------------------------------
    // clock, hang guard and closing report
    // ------------------------------------------------------------------
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // bus cycles and comparison
    // ------------------------------------------------------------------
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_clk(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic reg_wr(logic [11:0] a, logic [31:0] d);
        @(posedge clk_i);
        cfg_req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        cfg_req_i <= '0;
    endtask

    // rdata and rvalid stand just after the edge that takes the read, rvalid for one cycle, rdata until the next read
    task automatic reg_rd(string what, logic [11:0] a, logic [31:0] exp);
        @(posedge clk_i);
        cfg_req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk_i);
        cfg_req_i <= '0;
        #1;
        chk({what, " valid"}, 32'h1, {31'h0, cfg_rvalid_o});
        chk(what, exp, cfg_rdata_o);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_lane();
        reg_rd("config", `GPL_OFF_CONFIG, 32'h0);
        reg_rd("flags", `GPL_OFF_FLAGS, 32'h0);
        reg_rd("duty", `GPL_OFF_DUTY, 32'h0);
        reg_rd("ramp", `GPL_OFF_RAMP, 32'h0);
        reg_rd("divider", `GPL_OFF_DIVIDER, 32'h0);
        reg_wr(12'h640, 32'hFFFFFFFF);
        reg_rd("unmapped", 12'h640, 32'h0);
        chk("lane oe", 32'hF, {28'h0, general_io_pin_oe_o});
        chk("lane pins", 32'h3, {28'h0, general_io_pin_o});
        @(posedge clk_i);
        pin_function_select_i <= 1'b0;
        wait_clk(3);
        chk("io oe", 32'h0, {28'h0, general_io_pin_oe_o});
        $display("test reset_lane done");
    endtask

    task automatic t_static_out();
        reg_wr(`GPL_OFF_CONFIG, 32'h0000005F);
        wait_clk(3);
        chk("out oe", 32'hF, {28'h0, general_io_pin_oe_o});
        chk("out pins", 32'h5, {28'h0, general_io_pin_o});
        $display("test static_out done");
    endtask

    // both edges flag; write one clears only the written bits
    task automatic t_input_events();
        reg_wr(`GPL_OFF_CONFIG, 32'h000F0000);
        wait_clk(10);
        reg_wr(`GPL_OFF_FLAGS, 32'hF);
        ext_lvl <= 4'hA;
        wait_clk(10);
        reg_rd("levels", `GPL_OFF_CONFIG, 32'h0A0F0000);
        reg_rd("rise flags", `GPL_OFF_FLAGS, 32'hA);
        chk("pending", 32'h1, {31'h0, event_pending_o});
        reg_wr(`GPL_OFF_FLAGS, 32'h2);
        reg_rd("part clear", `GPL_OFF_FLAGS, 32'h8);
        reg_wr(`GPL_OFF_FLAGS, 32'h8);
        ext_lvl <= 4'h0;
        wait_clk(10);
        reg_rd("fall flags", `GPL_OFF_FLAGS, 32'hA);
        reg_wr(`GPL_OFF_FLAGS, 32'hF);
        wait_clk(2);
        chk("pending off", 32'h0, {31'h0, event_pending_o});
        $display("test input_events done");
    endtask

    task automatic t_debounce();
        reg_wr(`GPL_OFF_CONFIG, 32'h000FF000);
        wait_clk(2);
        ext_lvl <= 4'hF;
        wait_clk(2);
        ext_lvl <= 4'h0;
        wait_clk(20);
        reg_rd("glitch", `GPL_OFF_FLAGS, 32'h0);
        ext_lvl <= 4'hF;
        wait_clk(20);
        reg_rd("steady", `GPL_OFF_FLAGS, 32'hF);
        reg_wr(`GPL_OFF_FLAGS, 32'hF);
        $display("test debounce done");
    endtask

    // high clocks over one whole period are duty * 4 * divider, phase free
    task automatic t_pwm();
        int          hi [4];
        logic [31:0] d;
        d = 32'h8000FF40;
        reg_wr(`GPL_OFF_CONFIG, 32'h00000F0F);
        reg_wr(`GPL_OFF_DUTY, d);
        for (int dv = 1; dv <= 2; dv++) begin
            reg_wr(`GPL_OFF_DIVIDER, 32'(dv));
            wait_clk(1100);
            hi = '{0, 0, 0, 0};
            repeat (1024 * dv) begin
                wait_clk(1);
                for (int p = 0; p < 4; p++) hi[p] += int'(general_io_pin_o[p]);
            end
            for (int p = 0; p < 4; p++) begin
                chk("high clocks", 32'(d[8*p +: 8]) * 32'(4 * dv), 32'(hi[p]));
            end
        end
        $display("test pwm done");
    endtask

    task automatic t_ramp();
        reg_wr(`GPL_OFF_DIVIDER, 32'h1);
        reg_wr(`GPL_OFF_CONFIG, 32'h00200F0F);
        reg_wr(`GPL_OFF_DUTY, 32'h101002FD);
        reg_wr(`GPL_OFF_RAMP, 32'h04000101);
        wait_clk(10240);
        reg_rd("ramped duty", `GPL_OFF_DUTY, 32'h121000FF);
        reg_rd("ramp reg", `GPL_OFF_RAMP, 32'h04000101);
        $display("test ramp done");
    endtask

    // mid-run reset: default divider 00h makes step 0 last 1024 clocks,
    // less the 3 clocks spent programming duty and config after reset
    task automatic t_slow_div();
        int hi;
        hi = 0;
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        reg_wr(`GPL_OFF_DUTY, 32'h00000001);
        reg_wr(`GPL_OFF_CONFIG, 32'h00000101);
        repeat (1100) begin
            wait_clk(1);
            hi += int'(general_io_pin_o[0]);
        end
        chk("slow step high", 32'h000003FD, 32'(hi));
        $display("test slow_div done");
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        wait_clk(2);
        t_reset_lane();
        t_static_out();
        t_input_events();
        t_debounce();
        t_pwm();
        t_ramp();
        t_slow_div();
        end_sim();
    end
endmodule
